// file: design/psfm_regs.vh
// register map, field positions, reset values and timing figures of the power stage fault manager
`ifndef PSFM_REGS_VH
`define PSFM_REGS_VH

`define PSFM_ADDR_W          4
`define PSFM_OFS_CTRL        4'h0
`define PSFM_OFS_STATUS      4'h4
`define PSFM_OFS_STRAP       4'h8

`define PSFM_CTRL_MODE_LSB   0
`define PSFM_CTRL_MODE_MSB   1
`define PSFM_CTRL_SOFT_BIT   2
`define PSFM_CTRL_RST        3'h4

`define PSFM_MODE_BRIDGE     2'h0
`define PSFM_MODE_SINGLE     2'h1
`define PSFM_MODE_PARALLEL   2'h2

`define PSFM_STRAP_22K       2'h0
`define PSFM_STRAP_33K       2'h1
`define PSFM_STRAP_47K       2'h2

`define PSFM_RESP_OKAY       2'h0
`define PSFM_RESP_SLVERR     2'h2

`define PSFM_CLK_NS          10
`define PSFM_OL_PERSIST_NS   2000
`define PSFM_RCH_PERIOD_NS   2600
`define PSFM_RCH_WIDTH_NS    30
`define PSFM_SOFT_EDGES      16

`endif

// file: design/psfm_fault_manager.v
// fault supervision, isolation and flag reporting of a four half-bridge power stage
`timescale 1ns/1ns
`include "psfm_regs.vh"

// Operation
// - all half-bridges stay off until both supply monitors report good levels
// - shutdown and warning flags are active-low open-drain, only pulled low
// - any fault that shuts outputs pulls the shutdown flag low
// - warning flag is pulled low while the temperature warning indication is set
// - flag pair encodes error, overload/undervoltage, warning, or normal operation
// - either pair reset low releases the shutdown flag regardless of faults
// - a detected fault immediately turns the affected stage off and pulls shutdown low
// - faults auto-recover except overload and overtemperature error, which latch
// - bridge and single-ended modes isolate an overload per pair; parallel mode turns off all on either pair's overload
// - bootstrap undervoltage turns off only its own half-bridge
// - bootstrap undervoltage runs repeated recharge pulses until charged
// - overcurrent first limits output current instead of shutting down
// - persistent overcurrent latches an overload shutdown of affected half-bridges
// - current limit and overload detection act separately for pair AB and pair CD
// - one external strap selects the overcurrent threshold
// - with soft start, outputs enable only after switching has begun
// - rising edge of either pair reset clears a latched overload
// - asserting either pair reset clears the latched overtemperature error
// - a pair reset held low forces that pair off
module psfm_fault_manager #(
  parameter OL_PERSIST_NS = `PSFM_OL_PERSIST_NS,
  parameter RCH_PERIOD_NS = `PSFM_RCH_PERIOD_NS,
  parameter RCH_WIDTH_NS  = `PSFM_RCH_WIDTH_NS,
  parameter SOFT_EDGES    = `PSFM_SOFT_EDGES
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [3:0]  pwmIn,
  input  wire        reset_pair_ab_n,
  input  wire        reset_pair_cd_n,
  input  wire        gate_drive_supply,
  input  wire        coreSupplyOk,
  input  wire [3:0]  bootstrap_undervoltage,
  input  wire [3:0]  overcurrent,
  input  wire        tempWarning,
  input  wire        tempError,
  input  wire [1:0]  current_threshold_strap,
  output reg  [3:0]  halfBridgeEnable,
  output reg  [3:0]  pwmOut,
  output reg  [3:0]  weakPulldown,
  output reg  [3:0]  bootstrapRecharge,
  output reg  [1:0]  currentLimit,
  output reg  [1:0]  ocThresholdSel,
  output wire        fault_shutdown_n_o,
  output reg         fault_shutdown_n_oe,
  output wire        overtemp_warning_n_o,
  output reg         overtemp_warning_n_oe
);

  localparam OL_CYCLES  = (OL_PERSIST_NS + `PSFM_CLK_NS - 1) / `PSFM_CLK_NS;
  localparam RCH_PERIOD = RCH_PERIOD_NS / `PSFM_CLK_NS;
  localparam RCH_WIDTH  = (RCH_WIDTH_NS + `PSFM_CLK_NS - 1) / `PSFM_CLK_NS;
  localparam SYNC_W     = 12;

  // true when the counter has reached the last count of a span
  function atLast;
    input [15:0] cnt;
    input [15:0] span;
    begin
      atLast = (cnt >= span - 16'h0001);
    end
  endfunction

  // ---------------- synchronisers
  reg  [SYNC_W-1:0] syncMeta_r;
  reg  [SYNC_W-1:0] syncOut_r;
  wire [SYNC_W-1:0] rawIn;
  assign rawIn = {tempError, tempWarning, overcurrent, bootstrap_undervoltage, coreSupplyOk, gate_drive_supply};

  always @(posedge clock) begin
    if (sys_rst) begin
      syncMeta_r <= {SYNC_W{1'b0}};
      syncOut_r  <= {SYNC_W{1'b0}};
    end else begin
      syncMeta_r <= rawIn;
      syncOut_r  <= syncMeta_r;
    end
  end

  wire       supplyLow = ~(syncOut_r[0] & syncOut_r[1]);
  wire [3:0] bstLow    = syncOut_r[5:2];
  wire [3:0] ocNow     = syncOut_r[9:6];
  wire       warnNow   = syncOut_r[10];
  wire       errNow    = syncOut_r[11];

  // ---------------- control register and strap
  reg  [2:0] ctrl_r;
  reg  [1:0] strap_r;
  reg        strapTaken_r;
  wire [1:0] mode     = ctrl_r[`PSFM_CTRL_MODE_MSB:`PSFM_CTRL_MODE_LSB];
  wire       softEn   = ctrl_r[`PSFM_CTRL_SOFT_BIT];
  wire       parallel = (mode == `PSFM_MODE_PARALLEL);

  // strap is caught once, at the first edge after reset release
  always @(posedge clock) begin
    if (sys_rst) begin
      strap_r      <= `PSFM_STRAP_22K;
      strapTaken_r <= 1'b0;
    end else if (!strapTaken_r) begin
      strap_r      <= current_threshold_strap;
      strapTaken_r <= 1'b1;
    end
  end

  // ---------------- reset pins, edges
  reg rstAbPrev_r;
  reg rstCdPrev_r;
  always @(posedge clock) begin
    if (sys_rst) begin
      // pins idle high, so a pin already high at release is no edge
      rstAbPrev_r <= 1'b1;
      rstCdPrev_r <= 1'b1;
    end else begin
      rstAbPrev_r <= reset_pair_ab_n;
      rstCdPrev_r <= reset_pair_cd_n;
    end
  end
  wire rstRise  = (reset_pair_ab_n & ~rstAbPrev_r) | (reset_pair_cd_n & ~rstCdPrev_r);
  wire anyRstLo = ~reset_pair_ab_n | ~reset_pair_cd_n;

  // ---------------- overload detection per pair
  reg  [15:0] olCntAb_r;
  reg  [15:0] olCntCd_r;
  reg         olpAb_r;
  reg         olpCd_r;
  reg         ote_r;
  wire        ocAb = ocNow[0] | ocNow[1];
  wire        ocCd = ocNow[2] | ocNow[3];
  wire        olSetAb = ocAb & atLast(olCntAb_r, OL_CYCLES[15:0]);
  wire        olSetCd = ocCd & atLast(olCntCd_r, OL_CYCLES[15:0]);

  always @(posedge clock) begin
    if (sys_rst) begin
      olCntAb_r <= 16'h0000;
      olCntCd_r <= 16'h0000;
      olpAb_r   <= 1'b0;
      olpCd_r   <= 1'b0;
      ote_r     <= 1'b0;
    end else begin
      olCntAb_r <= (ocAb && !olSetAb) ? olCntAb_r + 16'h0001 : 16'h0000;
      olCntCd_r <= (ocCd && !olSetCd) ? olCntCd_r + 16'h0001 : 16'h0000;
      // a new overload on the clearing edge still latches
      if (olSetAb)
        olpAb_r <= 1'b1;
      else if (rstRise)
        olpAb_r <= 1'b0;
      if (olSetCd)
        olpCd_r <= 1'b1;
      else if (rstRise)
        olpCd_r <= 1'b0;
      if (errNow)
        ote_r <= 1'b1;
      else if (anyRstLo)
        ote_r <= 1'b0;
    end
  end

  // ---------------- isolation map
  wire globalOff = supplyLow | ote_r;
  wire offAb     = parallel ? (olpAb_r | olpCd_r) : olpAb_r;
  wire offCd     = parallel ? (olpAb_r | olpCd_r) : olpCd_r;
  wire pairOnAb  = reset_pair_ab_n & ~globalOff & ~offAb;
  wire pairOnCd  = reset_pair_cd_n & ~globalOff & ~offCd;

  // ---------------- soft start: count switching edges before enabling
  reg  [3:0]  pwmPrev_r;
  reg  [15:0] softAb_r;
  reg  [15:0] softCd_r;
  wire [3:0]  pwmRise = pwmIn & ~pwmPrev_r;
  wire        softDoneAb = ~softEn | (softAb_r >= SOFT_EDGES[15:0]);
  wire        softDoneCd = ~softEn | (softCd_r >= SOFT_EDGES[15:0]);

  always @(posedge clock) begin
    if (sys_rst) begin
      pwmPrev_r <= 4'h0;
      softAb_r  <= 16'h0000;
      softCd_r  <= 16'h0000;
    end else begin
      pwmPrev_r <= pwmIn;
      if (!pairOnAb)
        softAb_r <= 16'h0000;
      else if (pwmRise[0] && !softDoneAb)
        softAb_r <= softAb_r + 16'h0001;
      if (!pairOnCd)
        softCd_r <= 16'h0000;
      else if (pwmRise[2] && !softDoneCd)
        softCd_r <= softCd_r + 16'h0001;
    end
  end

  // ---------------- bootstrap recharge timer
  reg  [15:0] rchCnt_r;
  wire        rchPulse = (rchCnt_r < RCH_WIDTH[15:0]);
  always @(posedge clock) begin
    if (sys_rst)
      rchCnt_r <= 16'h0000;
    else if (atLast(rchCnt_r, RCH_PERIOD[15:0]))
      rchCnt_r <= 16'h0000;
    else
      rchCnt_r <= rchCnt_r + 16'h0001;
  end

  // ---------------- power stage outputs
  wire [3:0] pairOn   = {pairOnCd, pairOnCd, pairOnAb, pairOnAb};
  wire [3:0] softDone = {softDoneCd, softDoneCd, softDoneAb, softDoneAb};
  wire [3:0] limitHb  = {ocCd, ocCd, ocAb, ocAb};
  wire [3:0] halfOn   = pairOn & softDone & ~bstLow;
  wire       pdMode   = (mode != `PSFM_MODE_SINGLE);
  wire       anyFault = supplyLow | ote_r | olpAb_r | olpCd_r | (|bstLow);

  always @(posedge clock) begin
    if (sys_rst) begin
      halfBridgeEnable      <= 4'h0;
      pwmOut                <= 4'h0;
      weakPulldown          <= 4'h0;
      bootstrapRecharge     <= 4'h0;
      currentLimit          <= 2'h0;
      ocThresholdSel        <= `PSFM_STRAP_22K;
      fault_shutdown_n_oe   <= 1'b0;
      overtemp_warning_n_oe <= 1'b0;
    end else begin
      halfBridgeEnable      <= halfOn;
      // limiting cuts the high-side pulse short instead of tripping the stage
      pwmOut                <= pwmIn & halfOn & ~limitHb;
      weakPulldown          <= {{2{~reset_pair_cd_n & pdMode}}, {2{~reset_pair_ab_n & pdMode}}};
      bootstrapRecharge     <= bstLow & pairOn & {4{rchPulse}};
      currentLimit          <= {ocCd, ocAb};
      ocThresholdSel        <= strap_r;
      fault_shutdown_n_oe   <= anyFault & ~anyRstLo;
      overtemp_warning_n_oe <= warnNow | ote_r;
    end
  end

  assign fault_shutdown_n_o   = 1'b0;
  assign overtemp_warning_n_o = 1'b0;

  // ---------------- AXI4-Lite slave
  reg        awHave_r;
  reg        wHave_r;
  reg [3:0]  awAddr_r;
  reg [31:0] wData_r;
  reg [3:0]  wStrb_r;

  assign s_axi_awready = ~awHave_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHave_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire       awNow   = s_axi_awvalid & s_axi_awready;
  wire       wNow    = s_axi_wvalid & s_axi_wready;
  wire       awOk    = awHave_r | awNow;
  wire       wOk     = wHave_r | wNow;
  wire [3:0] wrAddr  = awHave_r ? awAddr_r : s_axi_awaddr;
  wire [31:0] wrData = wHave_r ? wData_r : s_axi_wdata;
  wire [3:0] wrStrb  = wHave_r ? wStrb_r : s_axi_wstrb;
  wire       doWrite = awOk & wOk & ~s_axi_bvalid;

  always @(posedge clock) begin
    if (sys_rst) begin
      awHave_r     <= 1'b0;
      wHave_r      <= 1'b0;
      awAddr_r     <= 4'h0;
      wData_r      <= 32'h00000000;
      wStrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PSFM_RESP_OKAY;
      ctrl_r       <= `PSFM_CTRL_RST;
    end else begin
      if (doWrite) begin
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wrAddr == `PSFM_OFS_CTRL) begin
          s_axi_bresp <= `PSFM_RESP_OKAY;
          if (wrStrb[0])
            ctrl_r <= wrData[2:0];
        end else if (wrAddr == `PSFM_OFS_STATUS || wrAddr == `PSFM_OFS_STRAP) begin
          s_axi_bresp <= `PSFM_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PSFM_RESP_SLVERR;
        end
      end else begin
        if (awNow) begin
          awHave_r <= 1'b1;
          awAddr_r <= s_axi_awaddr;
        end
        if (wNow) begin
          wHave_r <= 1'b1;
          wData_r <= s_axi_wdata;
          wStrb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [31:0] statusWord = {14'h0000, ocThresholdSel, ocNow, bstLow, currentLimit,
                            olpCd_r, olpAb_r, warnNow, ote_r, supplyLow, fault_shutdown_n_oe};

  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `PSFM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `PSFM_RESP_OKAY;
      case (s_axi_araddr)
        `PSFM_OFS_CTRL:   s_axi_rdata <= {29'h00000000, ctrl_r};
        `PSFM_OFS_STATUS: s_axi_rdata <= statusWord;
        `PSFM_OFS_STRAP:  s_axi_rdata <= {30'h00000000, strap_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PSFM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // psfm_fault_manager

// file: testbench/psfm_fault_manager_assertions.sv
// pin-level assertions for the power stage fault manager
`timescale 1ns/1ns
module psfm_fault_manager_checker (
  input wire       clock,
  input wire       sys_rst,
  input wire       reset_pair_ab_n,
  input wire       reset_pair_cd_n,
  input wire       gate_drive_supply,
  input wire       coreSupplyOk,
  input wire [3:0] bootstrap_undervoltage,
  input wire [3:0] overcurrent,
  input wire       tempWarning,
  input wire       tempError,
  input wire [3:0] halfBridgeEnable,
  input wire [3:0] pwmOut,
  input wire [3:0] bootstrapRecharge,
  input wire [1:0] currentLimit,
  input wire       fault_shutdown_n_o,
  input wire       fault_shutdown_n_oe,
  input wire       overtemp_warning_n_o,
  input wire       overtemp_warning_n_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire bothUp = reset_pair_ab_n && reset_pair_cd_n;
  // latched overload or temperature error would also stop recharge; the bench keeps them clear here
  wire bstCond = bootstrap_undervoltage[2] && bothUp && gate_drive_supply && coreSupplyOk;
  sequence bst_low_s;
    bstCond[*4];
  endsequence
  // delays assume two synchroniser stages plus the output register
  sequence hot_s;
    (tempError && bothUp)[*6];
  endsequence
  sequence overload_s;
    (overcurrent[0] && bothUp)[*8] ##1 bothUp[*4];
  endsequence
  flag_drive_a: assert property (!fault_shutdown_n_o && !overtemp_warning_n_o)
    else $error("flag pin driven high");
  supply_off_a: assert property (
    (!gate_drive_supply && bothUp)[*4] |-> halfBridgeEnable == 4'h0 && fault_shutdown_n_oe)
    else $error("stage not off on low supply");
  warn_flag_a: assert property (tempWarning |-> ##3 overtemp_warning_n_oe)
    else $error("warning flag not pulled");
  reset_release_a: assert property ((!reset_pair_ab_n || !reset_pair_cd_n) |=> !fault_shutdown_n_oe)
    else $error("shutdown flag pulled while reset low");
  pair_off_a: assert property (!reset_pair_cd_n |=> halfBridgeEnable[3:2] == 2'h0)
    else $error("pair on while its reset low");
  err_flags_a: assert property (
    hot_s |-> halfBridgeEnable == 4'h0 && fault_shutdown_n_oe && overtemp_warning_n_oe)
    else $error("error state not signalled");
  ote_latch_a: assert property (
    hot_s ##1 (!tempError && bothUp)[*8] |-> fault_shutdown_n_oe && halfBridgeEnable == 4'h0)
    else $error("temperature error not latched");
  climit_a: assert property (overcurrent[0] |-> ##3 currentLimit[0] && pwmOut[1:0] == 2'h0)
    else $error("current not limited");
  ol_latch_a: assert property (
    overload_s |-> fault_shutdown_n_oe && halfBridgeEnable[1:0] == 2'h0)
    else $error("overload not latched");
  bst_only_a: assert property (bootstrap_undervoltage[2] |-> ##3 !halfBridgeEnable[2])
    else $error("half-bridge on with low bootstrap");
  recharge_run_a: assert property (bst_low_s |-> ##[0:11] (bootstrapRecharge[2] || !bstCond))
    else $error("no recharge pulse on low bootstrap");
endmodule // psfm_fault_manager_checker

bind psfm_fault_manager psfm_fault_manager_checker chk (.clock, .sys_rst, .reset_pair_ab_n, .reset_pair_cd_n,
  .gate_drive_supply, .coreSupplyOk, .bootstrap_undervoltage, .overcurrent, .tempWarning, .tempError,
  .halfBridgeEnable, .pwmOut, .bootstrapRecharge, .currentLimit, .fault_shutdown_n_o, .fault_shutdown_n_oe,
  .overtemp_warning_n_o, .overtemp_warning_n_oe);

// file: testbench/psfm_modulator_model.sv
// behavioural pwm modulator and reset controller facing the fault manager
`timescale 1ns/1ns
module psfm_modulator_model #(
  parameter HOLD_CYCLES = 400000
) (
  input  wire       clock,
  input  wire [2:0] duty,
  input  wire       muteReq,
  input  wire       faultPin,
  input  wire       warnPin,
  output reg  [3:0] pwmIn,
  output reg        resetPairN
);
  reg [2:0]  phase_r = 3'h0;
  reg [19:0] since_r = 20'hfffff;
  reg        faultDly_r = 1'b1;
  initial pwmIn = 4'h0;
  initial resetPairN = 1'b0;
  always @(posedge clock) begin
    phase_r <= phase_r + 3'h1;
    // duty stays below 6 of 8, so each frame keeps at least 3 low cycles
    pwmIn <= (phase_r < duty) ? 4'hf : 4'h0;
    // a pending temperature warning halves the drive to cool the stage
    if (!warnPin) pwmIn <= (phase_r < {1'b0, duty[2:1]}) ? 4'hf : 4'h0;
    faultDly_r <= faultPin;
    if (faultDly_r && !faultPin) since_r <= 20'h0;
    else if (since_r != 20'hfffff) since_r <= since_r + 20'h1;
    if (muteReq) resetPairN <= 1'b0;
    else if (since_r >= HOLD_CYCLES) resetPairN <= 1'b1;
  end
endmodule // psfm_modulator_model

// file: testbench/psfm_fault_manager_bench.sv
// self-checking bench of the power stage fault manager
`timescale 1ns/1ns
`include "psfm_regs.vh"
module psfm_fault_manager_bench;
  reg         clock = 1'b0, sys_rst = 1'b1, smp = 1'b0, muteReq = 1'b1;
  reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, bootstrap_undervoltage = 4'h0, overcurrent = 4'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  reg         s_axi_rready = 1'b0, gate_drive_supply = 1'b1, coreSupplyOk = 1'b1, tempWarning = 1'b0;
  reg         tempError = 1'b0;
  reg  [1:0]  current_threshold_strap = 2'h0;
  reg  [2:0]  duty = 3'h0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, resetPairN;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0]  pwmIn, halfBridgeEnable, weakPulldown;
  wire [1:0]  ocThresholdSel;
  wire        fault_shutdown_n_o, fault_shutdown_n_oe, overtemp_warning_n_o, overtemp_warning_n_oe;
  integer     miscompares = 0, numChecks = 0, i;
  reg  [33:0] expQ [$];
  // open-drain flags with pull-ups
  wire        sdPin = fault_shutdown_n_oe ? fault_shutdown_n_o : 1'b1;
  wire        warnPin = overtemp_warning_n_oe ? overtemp_warning_n_o : 1'b1;

  psfm_fault_manager #(.OL_PERSIST_NS(50), .RCH_PERIOD_NS(100), .SOFT_EDGES(2)) dut (.clock, .sys_rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwmIn, .reset_pair_ab_n(resetPairN),
    .reset_pair_cd_n(resetPairN), .gate_drive_supply, .coreSupplyOk, .bootstrap_undervoltage, .overcurrent,
    .tempWarning, .tempError, .current_threshold_strap, .halfBridgeEnable, .pwmOut(), .weakPulldown,
    .bootstrapRecharge(), .currentLimit(), .ocThresholdSel, .fault_shutdown_n_o, .fault_shutdown_n_oe,
    .overtemp_warning_n_o, .overtemp_warning_n_oe);
  psfm_modulator_model #(.HOLD_CYCLES(20)) partner (.clock, .duty, .muteReq, .faultPin(sdPin), .warnPin,
    .pwmIn, .resetPairN);

  always #5 clock = ~clock;

  task complete_run;
    begin
      $display("checks %0d mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task check(input [33:0] seen, input [33:0] exp);
    begin
      numChecks = numChecks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task settle(input integer n);
    repeat (n) @(posedge clock);
  endtask
  task axiWrite(input [3:0] a, input [31:0] d, input [1:0] r);
    begin
      expQ.push_back({32'h0, r});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge clock);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bready && s_axi_bvalid) s_axi_bready <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    end
  endtask
  task axiRead(input [3:0] a, input [33:0] e);
    begin
      expQ.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge clock);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rready && s_axi_rvalid) s_axi_rready <= 1'b0;
      end while (s_axi_arvalid || s_axi_rready);
    end
  endtask
  // vector is {threshold select, shutdown pin, warning pin, weak pulldowns, half-bridge enables}
  task probe(input [9:0] v);
    begin
      expQ.push_back({22'h0, current_threshold_strap, v});
      smp <= 1'b1;
      @(posedge clock);
      smp <= 1'b0;
      @(posedge clock);
    end
  endtask
  task clearPairs(input [9:0] muted);
    begin
      muteReq <= 1'b1;
      settle(4);
      probe(muted);
      muteReq <= 1'b0;
      settle(30);
      probe(10'h30f);
    end
  endtask

  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, expQ.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
    if (smp) check({22'h0, ocThresholdSel, sdPin, warnPin, weakPulldown, halfBridgeEnable}, expQ.pop_front());
  end

  initial begin
    #100000;
    miscompares = miscompares + 1;
    complete_run;
  end

  initial begin
    i = $urandom(40288);
    current_threshold_strap <= $urandom % 3;
    settle(16);
    sys_rst <= 1'b0;
    muteReq <= 1'b0;
    // a zero duty would never switch, and soft start needs switching edges
    duty <= 3'h1 + $urandom % 5;
    axiRead(`PSFM_OFS_CTRL, {`PSFM_RESP_OKAY, 29'h0, `PSFM_CTRL_RST});
    axiRead(`PSFM_OFS_STRAP, {32'h0, current_threshold_strap});
    axiRead(4'hc, {`PSFM_RESP_SLVERR, 32'h0});
    axiWrite(4'hc, 32'h3, `PSFM_RESP_SLVERR);
    axiWrite(`PSFM_OFS_CTRL, 32'h0, `PSFM_RESP_OKAY);
    axiRead(`PSFM_OFS_CTRL, 34'h0);
    settle(8);
    probe(10'h30f);
    tempWarning <= 1'b1;
    settle(5);
    probe(10'h20f);
    tempWarning <= 1'b0;
    bootstrap_undervoltage <= 4'h4;
    // long enough for at least one recharge period
    settle(12);
    probe(10'h10b);
    bootstrap_undervoltage <= 4'h0;
    for (i = 0; i < 2; i = i + 1) begin
      {gate_drive_supply, coreSupplyOk} <= i ? 2'b01 : 2'b10;
      settle(5);
      probe(10'h100);
      {gate_drive_supply, coreSupplyOk} <= 2'b11;
      settle(5);
      probe(10'h30f);
    end
    duty <= 3'h1 + $urandom % 5;
    overcurrent <= 4'h1;
    settle(12);
    overcurrent <= 4'h0;
    settle(5);
    probe(10'h10c);
    // status: shutdown active and pair AB overload latched, threshold select on top
    axiRead(`PSFM_OFS_STATUS, {`PSFM_RESP_OKAY, 14'h0, current_threshold_strap, 16'h0011});
    clearPairs(10'h3f0);
    axiWrite(`PSFM_OFS_CTRL, {30'h0, `PSFM_MODE_PARALLEL}, `PSFM_RESP_OKAY);
    overcurrent <= 4'h4;
    settle(12);
    overcurrent <= 4'h0;
    settle(5);
    probe(10'h100);
    clearPairs(10'h3f0);
    axiWrite(`PSFM_OFS_CTRL, {30'h0, `PSFM_MODE_SINGLE}, `PSFM_RESP_OKAY);
    tempError <= 1'b1;
    settle(6);
    tempError <= 1'b0;
    settle(10);
    probe(10'h000);
    clearPairs(10'h300);
    axiWrite(`PSFM_OFS_CTRL, {29'h0, `PSFM_CTRL_RST}, `PSFM_RESP_OKAY);
    muteReq <= 1'b1;
    settle(4);
    probe(10'h3f0);
    muteReq <= 1'b0;
    settle(2);
    probe(10'h300);
    settle(30);
    probe(10'h30f);
    complete_run;
  end
endmodule // psfm_fault_manager_bench
